// ==== logic/timer_chan_pkg.sv ====
// constants shared by the timer channel control block
// assumes a 32-bit AHB-Lite register bus and a 16-bit shared counter
package timer_chan_pkg;
    // register byte offsets
    localparam logic [7:0] CSC_OFFS = 8'h00;
    localparam logic [7:0] VAL_LO_OFFS = 8'h04;
    localparam logic [7:0] VAL_HI_OFFS = 8'h08;
    localparam logic [7:0] GCTRL_OFFS = 8'h0C;
    // channel_status_control field positions
    localparam int FLAG_BIT = 7;
    localparam int IE_BIT = 6;
    localparam int MSB_BIT = 5;
    localparam int MSA_BIT = 4;
    localparam int ELS_HI = 3;
    localparam int ELS_LO = 2;
    // global control field position
    localparam int CAS_BIT = 0;
    // reset values
    localparam logic [7:0] CSC_RST = 8'h00;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic PIN_RST = 1'b0;
    // edge/level codes
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_LOW = 2'h2;
    localparam logic [1:0] ELS_HIGH = 2'h3;
    // pin must be steady this long before entering capture
    localparam int STEADY_NS = 20;
    localparam int CLK_NS = 10;
    localparam int STEADY_CYC = (STEADY_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_STAGES = 2;
    typedef enum {MODE_CAPTURE, MODE_COMPARE, MODE_EPWM, MODE_CPWM} chan_mode_t;
endpackage

// ==== logic/chan_pin_if.sv ====
// carries the synchronised channel pin and its edges
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface chan_pin_if;
    logic level;
    logic rise;
    logic fall;
    modport sync (output level, output rise, output fall);
    modport user (input level, input rise, input fall);
endinterface
`default_nettype wire

// ==== logic/chan_pin_sync.sv ====
// channel pin synchroniser with rise/fall detection
// assumes the pin may change at any time relative to ref_clk
`timescale 1ns/1ps
`default_nettype none
module chan_pin_sync #(
    parameter int STAGES = timer_chan_pkg::SYNC_STAGES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // raw pin level
    input wire logic pinRaw,
    // synchronised view
    chan_pin_if.sync pin
);
    logic [STAGES-1:0] sync_reg;
    logic last_reg;

    // first stage feeds only the next stage
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_reg <= '0;
            last_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[STAGES-2:0], pinRaw};
            last_reg <= sync_reg[STAGES-1];
        end
    end

    // detector runs in every mode, so a stale level never shows as an edge
    assign pin.level = sync_reg[STAGES-1];
    assign pin.rise = sync_reg[STAGES-1] && !last_reg;
    assign pin.fall = !sync_reg[STAGES-1] && last_reg;
endmodule
`default_nettype wire

// ==== logic/timer_chan_ctrl.sv ====
// timer channel status/control with capture, compare and pwm pin logic
// assumes an external 16-bit counter with a tick pulse and direction
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer_chan_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // shared counter
    input wire logic [15:0] cntValue,
    input wire logic cntTick,
    input wire logic cntUp,
    output logic cntUpDown,
    // channel pin
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    // interrupt request
    output logic chanIrq
);
    logic [7:0] csc_reg;
    logic cas_reg;
    logic armed_reg;
    logic [15:0] value_reg;
    logic [7:0] bufLo_reg;
    logic [7:0] bufHi_reg;
    logic loPend_reg;
    logic hiPend_reg;
    logic pinOut_reg;
    logic [31:0] hrdata_reg;
    logic wrPhase_reg;
    logic [7:0] wrAddr_reg;
    timer_chan_pkg::chan_mode_t mode;
    chan_pin_if pin ();

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chan_pin_sync #(.STAGES(timer_chan_pkg::SYNC_STAGES)) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pinRaw(pinIn),
        .pin(pin)
    );

    // bus decode; size is not checked, only word accesses are expected
    wire accept = hsel && htrans[1] && hready;
    wire rdAccept = accept && !hwrite;
    wire cscWr = wrPhase_reg && (wrAddr_reg == timer_chan_pkg::CSC_OFFS);
    wire loWr = wrPhase_reg && (wrAddr_reg == timer_chan_pkg::VAL_LO_OFFS);
    wire hiWr = wrPhase_reg && (wrAddr_reg == timer_chan_pkg::VAL_HI_OFFS);
    wire gWr = wrPhase_reg && (wrAddr_reg == timer_chan_pkg::GCTRL_OFFS);
    wire cscRd = rdAccept && (haddr == timer_chan_pkg::CSC_OFFS);

    // fields
    wire flag = csc_reg[timer_chan_pkg::FLAG_BIT];
    wire irqEn = csc_reg[timer_chan_pkg::IE_BIT];
    wire msUpper = csc_reg[timer_chan_pkg::MSB_BIT];
    wire msLower = csc_reg[timer_chan_pkg::MSA_BIT];
    wire [1:0] els = csc_reg[timer_chan_pkg::ELS_HI:timer_chan_pkg::ELS_LO];

    // center select overrides per-channel mode bits
    always_comb begin
        if (cas_reg) begin
            mode = timer_chan_pkg::MODE_CPWM;
        end else if (msUpper) begin
            mode = timer_chan_pkg::MODE_EPWM;
        end else if (msLower) begin
            mode = timer_chan_pkg::MODE_COMPARE;
        end else begin
            mode = timer_chan_pkg::MODE_CAPTURE;
        end
    end

    wire isCap = (mode == timer_chan_pkg::MODE_CAPTURE);
    wire isOc = (mode == timer_chan_pkg::MODE_COMPARE);
    wire isEpwm = (mode == timer_chan_pkg::MODE_EPWM);
    wire isCpwm = (mode == timer_chan_pkg::MODE_CPWM);

    // events
    wire capEvt = isCap && ((els[0] && pin.rise) || (els[1] && pin.fall));
    wire match = cntTick && (cntValue == value_reg);
    wire cmpEvt = !isCap && match;
    wire flagSet = capEvt || cmpEvt;
    wire clrReq = cscWr && !hwdata[timer_chan_pkg::FLAG_BIT] && armed_reg;
    wire periodStart = cntTick && (cntValue == 16'h0000);
    wire highTrue = (els == timer_chan_pkg::ELS_LOW);

    // set beats clear; a write of one never sets the flag
    wire flagNext = flagSet ? 1'b1 : (clrReq ? 1'b0 : flag);
    wire [7:0] csc_next = cscWr ? {flagNext, hwdata[6:0]} : {flagNext, csc_reg[6:0]};

    // arm on a read that sees the flag; any new event disarms
    wire armed_next = flagSet ? 1'b0 : (cscRd && flag) ? 1'b1 : cscWr ? 1'b0 : armed_reg;

    // pin action
    logic pinOut_next;
    always_comb begin
        pinOut_next = pinOut_reg;
        case (mode)
            timer_chan_pkg::MODE_COMPARE: begin
                if (match) begin
                    case (els)
                        timer_chan_pkg::ELS_TOGGLE: pinOut_next = !pinOut_reg;
                        timer_chan_pkg::ELS_LOW: pinOut_next = 1'b0;
                        timer_chan_pkg::ELS_HIGH: pinOut_next = 1'b1;
                        default: pinOut_next = pinOut_reg;
                    endcase
                end
            end
            timer_chan_pkg::MODE_EPWM: begin
                if (match) begin
                    pinOut_next = !highTrue;
                end else if (periodStart) begin
                    pinOut_next = highTrue;
                end
            end
            timer_chan_pkg::MODE_CPWM: begin
                if (match) begin
                    pinOut_next = highTrue ? !cntUp : cntUp;
                end
            end
            default: pinOut_next = pinOut_reg;
        endcase
    end

    // pin released when code is 00 or channel is capturing
    assign pinOe = !isCap && (els != timer_chan_pkg::ELS_OFF);
    assign pinOut = pinOut_reg;
    assign chanIrq = flag && irqEn;
    assign cntUpDown = cas_reg;

    // value register: two-byte write latch, capture loads directly
    wire xferLo = loWr && hiPend_reg;
    wire xferHi = hiWr && loPend_reg;
    wire [15:0] value_next = capEvt ? cntValue :
                             xferLo ? {bufHi_reg, hwdata[7:0]} :
                             xferHi ? {hwdata[7:0], bufLo_reg} : value_reg;
    wire loPend_next = !cscWr && !xferHi && (loWr || loPend_reg) && !xferLo;
    wire hiPend_next = !cscWr && !xferLo && (hiWr || hiPend_reg) && !xferHi;

    // read mux, unmapped reads zero
    wire [31:0] rdMux =
        (haddr == timer_chan_pkg::CSC_OFFS) ? {24'h000000, csc_reg} :
        (haddr == timer_chan_pkg::VAL_LO_OFFS) ? {24'h000000, value_reg[7:0]} :
        (haddr == timer_chan_pkg::VAL_HI_OFFS) ? {24'h000000, value_reg[15:8]} :
        (haddr == timer_chan_pkg::GCTRL_OFFS) ? {31'h00000000, cas_reg} : 32'h00000000;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPhase_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
        end else begin
            wrPhase_reg <= accept && hwrite;
            wrAddr_reg <= accept ? haddr : wrAddr_reg;
            hrdata_reg <= rdAccept ? rdMux : hrdata_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            csc_reg <= timer_chan_pkg::CSC_RST;
            armed_reg <= 1'b0;
            cas_reg <= 1'b0;
            pinOut_reg <= timer_chan_pkg::PIN_RST;
        end else begin
            csc_reg <= csc_next;
            armed_reg <= armed_next;
            cas_reg <= gWr ? hwdata[timer_chan_pkg::CAS_BIT] : cas_reg;
            pinOut_reg <= pinOut_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            value_reg <= timer_chan_pkg::VAL_RST;
            bufLo_reg <= 8'h00;
            bufHi_reg <= 8'h00;
            loPend_reg <= 1'b0;
            hiPend_reg <= 1'b0;
        end else begin
            value_reg <= value_next;
            bufLo_reg <= loWr ? hwdata[7:0] : bufLo_reg;
            bufHi_reg <= hiWr ? hwdata[7:0] : bufHi_reg;
            loPend_reg <= loPend_next;
            hiPend_reg <= hiPend_next;
        end
    end

    AST_CAP_SET: assert property (capEvt |=> flag)
        else $error("capture edge did not set flag");
    AST_CMP_SET: assert property (isOc && match |=> flag)
        else $error("compare match did not set flag");
    AST_CPWM_SET: assert property (isCpwm && match |=> flag)
        else $error("center pwm match did not set flag");
    AST_IRQ: assert property ($rose(flag) && irqEn |-> chanIrq)
        else $error("irq missing with flag and enable");
    AST_CLR_ARMED: assert property ($fell(flag) |-> $past(armed_reg) && $past(cscWr))
        else $error("flag cleared without read-then-write");
    AST_SET_WINS: assert property (flagSet && clrReq |=> flag ##1 !armed_reg || flag)
        else $error("event lost during clear");
    AST_W1_NONE: assert property (cscWr && hwdata[7] && !flag && !flagSet |=> !flag)
        else $error("writing one set the flag");
    AST_GPIO: assert property (els == timer_chan_pkg::ELS_OFF |-> !pinOe)
        else $error("pin driven with code 00");
    AST_TOGGLE: assert property (isOc && match && els == timer_chan_pkg::ELS_TOGGLE
        |=> pinOut != $past(pinOut))
        else $error("compare toggle missing");
    AST_EPWM_HT: assert property (isEpwm && match && highTrue |=> !pinOut)
        else $error("edge pwm high-true did not clear");
    AST_CPWM_UP: assert property (isCpwm && match && highTrue && cntUp |=> !pinOut)
        else $error("center pwm up-match did not clear");
    AST_LATCH_REL: assert property (cscWr |=> !loPend_reg && !hiPend_reg)
        else $error("value latch kept after control write");

    COV_CLEAR: cover property (cscRd && flag ##[2:5] clrReq);
    COV_RESTART: cover property (flagSet && clrReq);
    COV_EPWM: cover property (isEpwm && match ##[1:50] periodStart);
    COV_CPWM: cover property (isCpwm && match && !cntUp);
endmodule
`default_nettype wire

// ==== dv/chan_pin_model.sv ====
// far-side signal on the channel pin
// assumes the block drives the pin only while pinOe is high
`timescale 1ns/1ps
`default_nettype none
module chan_pin_model (
    // clock
    input wire logic ref_clk,
    // stimulus side
    input wire logic drvEn,
    input wire logic drvLevel,
    // block side
    input wire logic pinOut,
    input wire logic pinOe,
    output logic pinWire
);
    logic lastLevel = 1'b0;
    // released wire shows no stale level, so the inverse of the last one
    assign pinWire = pinOe ? pinOut : (drvEn ? drvLevel : ~lastLevel);
    always_ff @(posedge ref_clk) begin
        if (pinOe | drvEn) begin
            lastLevel <= pinWire;
        end
    end
endmodule
`default_nettype wire

// ==== dv/timer_chan_ctrl_bench.sv ====
// self-checking bench for the timer channel control block
// assumes zero-wait bus answers and a bench-driven counter
`timescale 1ns/1ps
`default_nettype none
module timer_chan_ctrl_bench;
    localparam logic [7:0] CSC = timer_chan_pkg::CSC_OFFS;
    logic ref_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic cntTick = 1'b0, cntUp = 1'b1, drvLevel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic [15:0] cntValue = 16'h0000;
    wire logic hready, hresp, cntUpDown, pinIn, pinOut, pinOe, chanIrq;
    int failures = 0, cmp_count = 0;
    timer_chan_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .cntValue(cntValue),
        .cntTick(cntTick), .cntUp(cntUp), .cntUpDown(cntUpDown), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .chanIrq(chanIrq));
    chan_pin_model pm (.ref_clk(ref_clk), .drvEn(1'b1), .drvLevel(drvLevel),
        .pinOut(pinOut), .pinOe(pinOe), .pinWire(pinIn));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task summarize;
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task rdy;
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                failures++;
                summarize;
            end
            @(posedge ref_clk);
        end
    endtask
    // one single transfer; hrdata taken at the edge ending the data phase
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        rdy;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rdy;
        q = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, {24'h0, d});
    endtask
    task ckCsc(input string nm, input logic [7:0] e);
        xfer(CSC, 1'b0, 32'h0);
        chk(nm, q, {24'h0, e});
    endtask
    // read then write zero to the flag
    task clr(input logic [7:0] cfg);
        xfer(CSC, 1'b0, 32'h0);
        wr(CSC, cfg);
    endtask
    task tick(input logic [15:0] v, input logic up);
        cntValue <= v;
        cntUp <= up;
        cntTick <= 1'b1;
        cyc(1);
        cntTick <= 1'b0;
        cyc(2);
    endtask
    task tReset;
        ckCsc("csc_rst", 8'h00);
        chk("irq_rst", chanIrq, 0);
        chk("oe_rst", pinOe, 0);
        chk("hresp", hresp, 0);
        xfer(8'h10, 1'b0, 32'h0);
        chk("unmapped", q, 0);
        wr(CSC, 8'hC0);
        ckCsc("flag_w1", 8'h40);
    endtask
    task tCap;
        logic [7:0] cfg;
        for (int c = 1; c < 4; c++) begin
            cfg = 8'h40 | 8'(c << 2);
            wr(CSC, cfg);
            cyc(4);
            clr(cfg);
            drvLevel <= 1'b1;
            cyc(6);
            ckCsc("rise", cfg | {c[0], 7'h0});
            chk("irq", chanIrq, c[0]);
            clr(cfg);
            drvLevel <= 1'b0;
            cyc(6);
            ckCsc("fall", cfg | {c[1], 7'h0});
            clr(cfg);
        end
    endtask
    task tClear;
        drvLevel <= 1'b1;
        cyc(6);
        wr(CSC, 8'h4C);
        ckCsc("no_arm", 8'hCC);
        drvLevel <= 1'b0;
        cyc(6);
        wr(CSC, 8'h4C);
        ckCsc("restart", 8'hCC);
        clr(8'h4C);
        ckCsc("cleared", 8'h4C);
        chk("irq_off", chanIrq, 0);
    endtask
    task tCmp;
        logic [2:0] cs [5] = '{3, 2, 1, 1, 0};
        logic ex [5] = '{1, 0, 1, 0, 0};
        logic [7:0] cfg;
        // half pair left over, then dropped by a control write
        wr(8'h08, 8'h55);
        wr(CSC, 8'h10);
        wr(8'h04, 8'h34);
        wr(8'h08, 8'h12);
        xfer(8'h08, 1'b0, 32'h0);
        chk("val_hi", q, 32'h00000012);
        xfer(8'h04, 1'b0, 32'h0);
        chk("val_lo", q, 32'h00000034);
        for (int i = 0; i < 5; i++) begin
            cfg = 8'h10 | {4'h0, cs[i][1:0], 2'h0};
            wr(CSC, cfg);
            clr(cfg);
            tick(16'h1235, 1'b1);
            ckCsc("nomatch", cfg);
            tick(16'h1234, 1'b1);
            if (cs[i] != 0) chk("cmp_pin", pinOut, ex[i]);
            chk("cmp_oe", pinOe, cs[i] != 0);
            ckCsc("cmp_flag", cfg | 8'h80);
            clr(cfg);
        end
    endtask
    task tPwm(input logic center);
        logic [7:0] cfg;
        wr(8'h0C, {7'h0, center});
        // register loads at the edge that ended the write; look one edge later
        cyc(1);
        chk("updown", cntUpDown, center);
        for (int c = 1; c < 3; c++) begin
            cfg = (center ? 8'h00 : 8'h20) | 8'(c << 2);
            wr(CSC, cfg);
            clr(cfg);
            tick(16'h0000, 1'b1);
            if (!center) chk("epwm_start", pinOut, c == 2);
            tick(16'h1234, 1'b1);
            chk("pwm_up", pinOut, c != 2);
            ckCsc("pwm_flag", cfg | 8'h80);
            clr(cfg);
            tick(16'h1234, 1'b0);
            if (center) chk("cpwm_dn", pinOut, c == 2);
            if (center) ckCsc("cpwm_flag", cfg | 8'h80);
            clr(cfg);
        end
        wr(8'h0C, 8'h00);
    endtask
    initial begin
        cyc(12);
        rst_b <= 1'b1;
        cyc(1);
        tReset;
        tCap;
        tClear;
        tCmp;
        tPwm(1'b0);
        tPwm(1'b1);
        summarize;
    end
endmodule
`default_nettype wire
